// File: hdl/aicp_map.vh
// Function
// - Bytes are eight bits, MSB first
// - Receiver acknowledges in ninth clock
// - SDA fall/rise with SCL high: start/stop
// - Master changes SDA only while SCL low
// - First byte: address then direction bit
// - Any byte count; stop ends transfer (host moves one data byte per transfer)
// - Write: addr+0, register, data, stop
// - Read: register, repeated start, addr+1
// - Master nacks read byte then stops
// - Lines driven low only, open drain
`ifndef AICP_MAP_VH
`define AICP_MAP_VH
// APB register offsets (byte addresses)
`define AICP_OFS_CTRL 12'h000
`define AICP_OFS_ADDR 12'h004
`define AICP_OFS_WDATA 12'h008
`define AICP_OFS_STATUS 12'h00c
`define AICP_OFS_RDATA 12'h010
`define AICP_OFS_DIV 12'h014
// Control register fields
`define AICP_CTRL_GO 0
`define AICP_CTRL_READ 1
// Status register fields
`define AICP_ST_BUSY 0
`define AICP_ST_NACK 1
`define AICP_ST_DONE 2
// Device address
`define AICP_DEV_UPPER 6'h36
`define AICP_ADDR_RESET 1'h0
// Device register map
`define AICP_REG_IDENTITY 8'h00
`define AICP_REG_POWER 8'h01
`define AICP_POWER_RESET 8'hfd
`define AICP_SLEEP_BIT 1
`define AICP_SHUTDOWN_BIT 0
// Quarter bit period in pclk cycles: 25 MHz / (4*100 kHz) = 62.5 -> 63
`define AICP_CLK_HZ 25000000
`define AICP_STD_HZ 100000
`define AICP_FAST_HZ 400000
`define AICP_QTR_STD ((`AICP_CLK_HZ + 4*`AICP_STD_HZ - 1) / (4*`AICP_STD_HZ))
`define AICP_QTR_FAST ((`AICP_CLK_HZ + 4*`AICP_FAST_HZ - 1) / (4*`AICP_FAST_HZ))
`endif

// File: hdl/aicp_tick.v
`timescale 1ns/10ps
`include "aicp_map.vh"
module aicp_tick (
	pclk,
	presetn,
	fast,
	run,
	tick
);
input wire pclk;
input wire presetn;
input wire fast;
input wire run;
output reg tick;
reg [7:0] cnt;
wire [7:0] limit;
// Both counts fit in eight bits, so the upper bits are cut on purpose
localparam [31:0] LIM_STD = `AICP_QTR_STD - 1;
localparam [31:0] LIM_FAST = `AICP_QTR_FAST - 1;
assign limit = fast ? LIM_FAST[7:0] : LIM_STD[7:0];
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt <= 8'h00;
		tick <= 1'b0;
	end else if (!run) begin
		cnt <= 8'h00;
		tick <= 1'b0;
	end else if (cnt >= limit) begin
		cnt <= 8'h00;
		tick <= 1'b1;
	end else begin
		cnt <= cnt + 8'h01;
		tick <= 1'b0;
	end
end
endmodule

// File: hdl/aicp_sync.v
`timescale 1ns/10ps
module aicp_sync (
	pclk,
	presetn,
	din,
	dout
);
input wire pclk;
input wire presetn;
input wire [1:0] din;
output reg [1:0] dout;
reg [1:0] meta;
// Pull-ups idle high, so reset to ones
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		meta <= 2'h3;
		dout <= 2'h3;
	end else begin
		meta <= din;
		dout <= meta;
	end
end
endmodule

// File: hdl/aicp_host.v
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "aicp_map.vh"
module aicp_host (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	bus_clock_in,
	bus_clock_out,
	bus_clock_oe,
	bus_data_in,
	bus_data_out,
	bus_data_oe,
	gain_sel_high
);
input wire pclk;
input wire presetn;
input wire psel;
input wire penable;
input wire pwrite;
input wire [11:0] paddr;
input wire [31:0] pwdata;
output reg [31:0] prdata;
output reg pready;
output reg pslverr;
input wire bus_clock_in;
output reg bus_clock_out;
output reg bus_clock_oe;
input wire bus_data_in;
output reg bus_data_out;
output reg bus_data_oe;
output reg gain_sel_high;

localparam S_IDLE = 4'h0;
localparam S_START = 4'h1;
localparam S_BIT = 4'h2;
localparam S_ACK = 4'h3;
localparam S_RSTART = 4'h4;
localparam S_RBIT = 4'h5;
localparam S_MNACK = 4'h6;
localparam S_STOP = 4'h7;
localparam S_DONE = 4'h8;

////////////////////////////////////////////////////////////////////////
// Registers
reg [6:0] dev_addr;
reg [7:0] reg_index;
reg [7:0] wdata;
reg [7:0] rdata;
reg fast;
reg op_read;
reg busy;
reg nack;
reg done;
reg [3:0] state;
reg [1:0] phase;
reg [3:0] bitn;
reg [1:0] byten;
reg [7:0] shreg;
reg drive_low;
reg clock_low;
wire tick;
wire [1:0] lines;
wire scl_s;
wire sda_s;
wire access;
wire go;

assign access = psel & penable & pready;
assign go = access & pwrite & (paddr == `AICP_OFS_CTRL) &
	pwdata[`AICP_CTRL_GO] & ~busy;
assign scl_s = lines[1];
assign sda_s = lines[0];

// Line inputs come from the open-drain wire, not our clock
aicp_sync u_sync (
	.pclk(pclk),
	.presetn(presetn),
	.din({bus_clock_in, bus_data_in}),
	.dout(lines)
);

aicp_tick u_tick (
	.pclk(pclk),
	.presetn(presetn),
	.fast(fast),
	.run(busy),
	.tick(tick)
);

////////////////////////////////////////////////////////////////////////
// APB slave; no wait cycles, prdata is registered in the setup cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
		dev_addr <= {`AICP_DEV_UPPER, `AICP_ADDR_RESET};
		reg_index <= 8'h00;
		wdata <= 8'h00;
		fast <= 1'b0;
		op_read <= 1'b0;
		gain_sel_high <= 1'b0;
	end else begin
		pready <= psel & ~pready;
		pslverr <= 1'b0;
		if (psel & ~pready) begin
			case (paddr)
			`AICP_OFS_CTRL: prdata <= {28'h0, gain_sel_high, fast, op_read, 1'b0};
			`AICP_OFS_ADDR: prdata <= {17'h0, dev_addr, reg_index};
			`AICP_OFS_WDATA: prdata <= {24'h0, wdata};
			`AICP_OFS_STATUS: prdata <= {28'h0, scl_s, done, nack, busy};
			`AICP_OFS_RDATA: prdata <= {24'h0, rdata};
			default: prdata <= 32'h00000000;
			endcase
			pslverr <= (paddr > `AICP_OFS_RDATA) | (paddr[1:0] != 2'h0);
		end
		if (access & pwrite & ~busy) begin
			case (paddr)
			`AICP_OFS_CTRL: begin
				op_read <= pwdata[`AICP_CTRL_READ];
				fast <= pwdata[2];
				gain_sel_high <= pwdata[3];
			end
			`AICP_OFS_ADDR: begin
				reg_index <= pwdata[7:0];
				dev_addr <= pwdata[14:8];
			end
			`AICP_OFS_WDATA: wdata <= pwdata[7:0];
			default: ;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Bus engine: four quarter phases per bit
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state <= S_IDLE;
		phase <= 2'h0;
		bitn <= 4'h0;
		byten <= 2'h0;
		shreg <= 8'h00;
		drive_low <= 1'b0;
		clock_low <= 1'b0;
		busy <= 1'b0;
		nack <= 1'b0;
		done <= 1'b0;
		rdata <= 8'h00;
	end else if (go) begin
		busy <= 1'b1;
		nack <= 1'b0;
		done <= 1'b0;
		state <= S_START;
		phase <= 2'h0;
		byten <= 2'h0;
		bitn <= 4'h0;
		shreg <= {dev_addr, 1'b0};
	// Clear only a done that this read reported, or a late done is lost
	end else if (access & ~pwrite & (paddr == `AICP_OFS_STATUS) &
		prdata[`AICP_ST_DONE]) begin
		done <= 1'b0;
	end else if (tick) begin
		phase <= phase + 2'h1;
		case (state)
		S_START, S_RSTART: begin
			// SDA falls while SCL high
			case (phase)
			2'h0: begin
				clock_low <= 1'b1;
				drive_low <= 1'b0;
			end
			2'h1: clock_low <= 1'b0;
			2'h2: drive_low <= 1'b1;
			default: begin
				clock_low <= 1'b1;
				state <= S_BIT;
				bitn <= 4'h0;
			end
			endcase
		end
		S_BIT, S_RBIT: begin
			case (phase)
			2'h0: drive_low <= (state == S_BIT) ? ~shreg[7] : 1'b0;
			2'h1: clock_low <= 1'b0;
			2'h2: if (state == S_RBIT) shreg <= {shreg[6:0], sda_s};
			default: begin
				clock_low <= 1'b1;
				if (state == S_BIT) shreg <= {shreg[6:0], 1'b0};
				bitn <= bitn + 4'h1;
				if (bitn == 4'h7)
					state <= (state == S_BIT) ? S_ACK : S_MNACK;
			end
			endcase
		end
		S_ACK: begin
			case (phase)
			2'h0: drive_low <= 1'b0;
			2'h1: clock_low <= 1'b0;
			2'h2: nack <= sda_s;
			default: begin
				clock_low <= 1'b1;
				bitn <= 4'h0;
				byten <= byten + 2'h1;
				if (nack)
					state <= S_STOP;
				else if (byten == 2'h0) begin
					state <= S_BIT;
					shreg <= reg_index;
				end else if (byten == 2'h1 && op_read) begin
					state <= S_RSTART;
					shreg <= {dev_addr, 1'b1};
				end else if (byten == 2'h1) begin
					state <= S_BIT;
					shreg <= wdata;
				end else if (byten == 2'h2 && op_read) begin
					state <= S_RBIT;
				end else begin
					state <= S_STOP;
				end
			end
			endcase
		end
		S_MNACK: begin
			case (phase)
			2'h0: begin
				drive_low <= 1'b0;
				rdata <= shreg;
			end
			2'h1: clock_low <= 1'b0;
			2'h2: ;
			default: begin
				clock_low <= 1'b1;
				state <= S_STOP;
			end
			endcase
		end
		S_STOP: begin
			// SDA rises while SCL high
			case (phase)
			2'h0: drive_low <= 1'b1;
			2'h1: clock_low <= 1'b0;
			2'h2: drive_low <= 1'b0;
			default: state <= S_DONE;
			endcase
		end
		S_DONE: begin
			busy <= 1'b0;
			done <= 1'b1;
			state <= S_IDLE;
		end
		default: state <= S_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Open-drain pins: only ever drive low
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		bus_clock_out <= 1'b0;
		bus_clock_oe <= 1'b0;
		bus_data_out <= 1'b0;
		bus_data_oe <= 1'b0;
	end else begin
		bus_clock_out <= 1'b0;
		bus_clock_oe <= clock_low;
		bus_data_out <= 1'b0;
		bus_data_oe <= drive_low;
	end
end
// Clock stretching is not honoured; scl_s only shows the line in status
endmodule

// File: verif/aicp_props.sv
`timescale 1ns/10ps
module aicp_props (
	input wire pclk,
	input wire presetn,
	input wire bus_clock_oe,
	input wire bus_clock_out,
	input wire bus_data_oe,
	input wire bus_data_out
);
reg [3:0] cnt;
reg pc;
wire up = pc && !bus_clock_oe;
wire hi = !pc && !bus_clock_oe;
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// Bit index within a nine-clock unit; a start realigns it
always @(posedge pclk or negedge presetn)
	if (!presetn) begin
		pc <= 1'b0;
		cnt <= 4'h0;
	end else begin
		pc <= bus_clock_oe;
		if (up)
			cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
		else if (hi && $rose(bus_data_oe))
			cnt <= 4'h0;
	end
////////////////////////////////
property p_od; !bus_clock_out && !bus_data_out; endproperty
a_od: assert property (p_od) else $error("high");
property p_ack; up && cnt == 4'h8 |-> !bus_data_oe [*8]; endproperty
a_ack: assert property (p_ack) else $error("ack");
property p_hold; up |-> $stable(bus_data_oe) [*8]; endproperty
a_hold: assert property (p_hold) else $error("hold");
property p_start; hi && $rose(bus_data_oe) |-> ##[2:70] bus_clock_oe;
endproperty
a_start: assert property (p_start) else $error("start");
property p_stop; hi && $fell(bus_data_oe) |=> !bus_clock_oe [*8];
endproperty
a_stop: assert property (p_stop) else $error("stop");
property p_unit; hi && $fell(bus_data_oe) |-> cnt == 4'h1; endproperty
a_unit: assert property (p_unit) else $error("unit");
property p_high; up |-> !bus_clock_oe [*8]; endproperty
a_high: assert property (p_high) else $error("short");
property p_low;
	$rose(bus_clock_oe) |-> bus_clock_oe [*8] ##[1:300] !bus_clock_oe;
endproperty
a_low: assert property (p_low) else $error("long");
endmodule
bind aicp_host aicp_props u_aicp_props (.pclk(pclk), .presetn(presetn),
	.bus_clock_oe(bus_clock_oe), .bus_clock_out(bus_clock_out),
	.bus_data_oe(bus_data_oe), .bus_data_out(bus_data_out));

// File: verif/aicp_dev.sv
`timescale 1ns/10ps
module aicp_dev #(
	parameter [7:0] ID = 8'h5a // Arbitrary value
) (
	input wire scl,
	input wire sda,
	input wire strap,
	input wire gain,
	output reg sda_oe = 1'b0
);
reg [7:0] sr, q, ptr, pwr = 8'hfd;
reg a0, rd, hit, tx, act = 1'b0;
integer n, bi;
wire asleep = pwr[1];
initial #1 a0 = strap;
always @(negedge sda)
	if (scl && gain) begin
		act = 1'b1;
		tx = 1'b0;
		n = 0;
		bi = 0;
	end
always @(posedge sda)
	if (scl)
		act = 1'b0;
always @(posedge scl)
	if (act) begin
		if (tx && n == 8 && sda)
			act = 1'b0;
		sr = {sr[6:0], sda};
		n = n + 1;
	end
// Released each falling clock, so an ack never leaks into the next bit
always @(negedge scl)
	if (act) begin
		sda_oe = 1'b0;
		if (n == 9) begin
			n = 0;
			tx = rd;
		end
		if (tx && n < 8)
			sda_oe = !q[7 - n];
		else if (!tx && n == 8) begin
			if (bi == 0)
				{hit, rd} = {sr[7:1] == {6'h36, a0}, sr[0]};
			if (bi == 1)
				ptr = sr;
			if (bi == 2 && ptr == 8'h01)
				pwr = sr;
			q = (ptr == 8'h01) ? pwr : ID;
			sda_oe = hit;
			act = hit;
			bi = bi + 1;
		end
	end
endmodule

// File: verif/tb_amp_i2c_control_port.sv
`timescale 1ns/10ps
module tb_amp_i2c_control_port;
localparam [7:0] ID = 8'h5a; // Arbitrary value
reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, rd;
reg err = 1'b0;
reg [7:0] pw = 8'hfd, r = 8'h27;
integer fails = 0, checked = 0, i, n;
wire [31:0] prdata;
wire pready, pslverr, scl_oe, sda_oe, gain, dev_oe;
// Pull-ups: a line is high unless some party pulls it
wire scl = !scl_oe;
wire sda = !(sda_oe || dev_oe);
aicp_host u_aicp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.bus_clock_in(scl), .bus_clock_out(), .bus_clock_oe(scl_oe),
	.bus_data_in(sda), .bus_data_out(), .bus_data_oe(sda_oe),
	.gain_sel_high(gain));
aicp_dev #(.ID(ID)) u_aicp_dev (.scl(scl), .sda(sda), .strap(1'b0),
	.gain(gain), .sda_oe(dev_oe));
always #20 pclk = !pclk;
function [7:0] lfsr(input [7:0] s);
	lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
endfunction
function [7:0] want(input [7:0] a);
	want = (a == 8'h01) ? pw : ID;
endfunction
task give_verdict;
	begin
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
endtask
task chk(input [31:0] g, input [31:0] e);
	begin
		checked = checked + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	end
endtask
task hang(input integer k);
	if (k >= 5000) begin
		fails = fails + 1;
		give_verdict;
	end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 5000);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		hang(n);
	end
endtask
task xfer(input op, input [6:0] sa, input [7:0] ra, input [7:0] wd,
	input fast, input nk);
	integer k;
	begin
		apb(1'b1, 12'h004, {17'h0, sa, ra});
		apb(1'b1, 12'h008, {24'h0, wd});
		apb(1'b1, 12'h000, {28'h0, 1'b1, fast, op, 1'b1});
		k = 0;
		do begin
			apb(1'b0, 12'h00c, 32'h0);
			k = k + 1;
		end while (rd[2] !== 1'b1 && k < 5000);
		hang(k);
		chk(rd, {28'h0, 1'b1, 1'b1, nk, 1'b0});
		apb(1'b0, 12'h010, 32'h0);
		if (op && !nk)
			chk(rd, {24'h0, want(ra)});
	end
endtask
initial begin
	repeat (5) @(posedge pclk);
	presetn <= 1'b1;
	apb(1'b0, 12'h004, 32'h0);
	chk(rd, 32'h00006c00);
	apb(1'b0, 12'h020, 32'h0);
	chk({31'h0, err}, 32'h1);
	xfer(1'b1, 7'h6c, 8'h01, 8'h00, 1'b1, 1'b0);
	apb(1'b0, 12'h000, 32'h0);
	chk(rd, 32'h0000000e);
	$display("reset test done");
	// Standard rate first, then fast, to keep the run short
	for (i = 0; i < 6; i = i + 1) begin
		r = lfsr(r);
		xfer(1'b0, 7'h6c, {7'h0, i[0]}, r, i > 1, 1'b0);
		if (i[0])
			pw = r;
		xfer(1'b1, 7'h6c, {7'h0, i[0]}, 8'h00, i > 1, 1'b0);
	end
	$display("register test done");
	xfer(1'b0, 7'h6d, 8'h01, 8'h00, 1'b1, 1'b1);
	xfer(1'b1, 7'h6c, 8'h01, 8'h00, 1'b1, 1'b0);
	$display("address test done");
	give_verdict;
end
endmodule
